// *** rtl/cidtr_pkg.sv ***
// Constants and code checks for the chip identification and TAP reset control block.
// Behaviour
// - Fields: ext 31, type 30..28, architecture_code 27..20, sram 19..16, mem2/mem1 15..8, proc 7..5, version 4..0.
// - Second program memory size uses the 4-bit size code table; other codes reserved.
// - SRAM size uses its own 4-bit code table; the remaining codes are reserved.
// - Memory type is a 3-bit code: ROM, ROMless/flash, SRAM-as-ROM, flash, ROM plus flash.
// - For ROM plus flash, first size field is ROM, second is flash.
// - Extension flag is 1 only when an extension register exists.
// - Extension register reads all zeros while the extension flag is 0.
// - With force bit 0 clear, emulator reset passes straight to the TAP reset; here it is synchronised in two stages and registered, three clocks late.
// - With force bit 0 set, TAP reset is held low regardless of emulator reset.
package cidtr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the bus.
	localparam int unsigned CIDTR_ADDR_W = 8;
	localparam logic [7:0] CIDTR_OFF_CID = 8'h00;
	localparam logic [7:0] CIDTR_OFF_XTN = 8'h04;
	localparam logic [7:0] CIDTR_OFF_OVR = 8'h08;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the identification word, and of the force bit in the override register.
	localparam int unsigned CIDTR_EXT_POS = 31;
	localparam int unsigned CIDTR_TYPE_LSB = 28;
	localparam int unsigned CIDTR_ARCHITECTURE_CODE_LSB = 20;
	localparam int unsigned CIDTR_SRAM_LSB = 16;
	localparam int unsigned CIDTR_MEM2_LSB = 12;
	localparam int unsigned CIDTR_MEM1_LSB = 8;
	localparam int unsigned CIDTR_PROC_LSB = 5;
	localparam int unsigned CIDTR_VER_LSB = 0;
	localparam int unsigned CIDTR_FORCE_POS = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic CIDTR_FORCE_RST = 1'h0;
	localparam logic [31:0] CIDTR_DATA_RST = 32'h0000_0000;
	localparam logic CIDTR_TAP_RST = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Program memory type codes.
	localparam logic [2:0] CIDTR_TYPE_ROM = 3'h0;
	localparam logic [2:0] CIDTR_TYPE_ROMLESS = 3'h1;
	localparam logic [2:0] CIDTR_TYPE_EFLASH = 3'h2;
	localparam logic [2:0] CIDTR_TYPE_ROM_EFLASH = 3'h3;
	localparam logic [2:0] CIDTR_TYPE_SRAM_EMU = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Program memory size codes, shared by both size fields.
	localparam logic [3:0] CIDTR_MSZ_NONE = 4'h0;
	localparam logic [3:0] CIDTR_MSZ_8K = 4'h1;
	localparam logic [3:0] CIDTR_MSZ_16K = 4'h2;
	localparam logic [3:0] CIDTR_MSZ_32K = 4'h3;
	localparam logic [3:0] CIDTR_MSZ_64K = 4'h5;
	localparam logic [3:0] CIDTR_MSZ_128K = 4'h7;
	localparam logic [3:0] CIDTR_MSZ_256K = 4'h9;
	localparam logic [3:0] CIDTR_MSZ_512K = 4'hA;
	localparam logic [3:0] CIDTR_MSZ_1024K = 4'hC;
	localparam logic [3:0] CIDTR_MSZ_2048K = 4'hE;

	////////////////////////////////////////////////////////////////////////////////
	// SRAM size codes.
	localparam logic [3:0] CIDTR_SSZ_1K = 4'h1;
	localparam logic [3:0] CIDTR_SSZ_2K = 4'h2;
	localparam logic [3:0] CIDTR_SSZ_4K = 4'h5;
	localparam logic [3:0] CIDTR_SSZ_160K = 4'h7;
	localparam logic [3:0] CIDTR_SSZ_8K = 4'h8;
	localparam logic [3:0] CIDTR_SSZ_16K = 4'h9;
	localparam logic [3:0] CIDTR_SSZ_32K = 4'hA;
	localparam logic [3:0] CIDTR_SSZ_64K = 4'hB;
	localparam logic [3:0] CIDTR_SSZ_128K = 4'hC;
	localparam logic [3:0] CIDTR_SSZ_256K = 4'hD;
	localparam logic [3:0] CIDTR_SSZ_96K = 4'hE;
	localparam logic [3:0] CIDTR_SSZ_512K = 4'hF;

	////////////////////////////////////////////////////////////////////////////////
	// Code checks used at elaboration and by assertions.
	function automatic logic cidtr_msz_ok(input logic [3:0] c);
		case (c)
			CIDTR_MSZ_NONE, CIDTR_MSZ_8K, CIDTR_MSZ_16K, CIDTR_MSZ_32K, CIDTR_MSZ_64K,
			CIDTR_MSZ_128K, CIDTR_MSZ_256K, CIDTR_MSZ_512K, CIDTR_MSZ_1024K, CIDTR_MSZ_2048K: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : cidtr_msz_ok

	function automatic logic cidtr_ssz_ok(input logic [3:0] c);
		case (c)
			CIDTR_SSZ_1K, CIDTR_SSZ_2K, CIDTR_SSZ_4K, CIDTR_SSZ_160K, CIDTR_SSZ_8K, CIDTR_SSZ_16K,
			CIDTR_SSZ_32K, CIDTR_SSZ_64K, CIDTR_SSZ_128K, CIDTR_SSZ_256K, CIDTR_SSZ_96K, CIDTR_SSZ_512K: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : cidtr_ssz_ok

	function automatic logic cidtr_type_ok(input logic [2:0] c);
		case (c)
			CIDTR_TYPE_ROM, CIDTR_TYPE_ROMLESS, CIDTR_TYPE_EFLASH, CIDTR_TYPE_ROM_EFLASH,
			CIDTR_TYPE_SRAM_EMU: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : cidtr_type_ok

endpackage : cidtr_pkg

// *** rtl/cidtr_sync.sv ***
// Two-stage synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module cidtr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_q;

	// The first stage feeds only the second one.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : cidtr_sync

// *** rtl/cidtr_id_word.sv ***
// Assembles the constant identification and extension words from the strapped codes.
`timescale 1ns/1ps
module cidtr_id_word #(
	parameter logic EXTENSION_FLAG = 1'b0,
	parameter logic [2:0] MEM_TYPE = cidtr_pkg::CIDTR_TYPE_EFLASH,
	parameter logic [7:0] ARCHITECTURE_CODE = 8'hA5,
	parameter logic [3:0] SRAM_SIZE = cidtr_pkg::CIDTR_SSZ_8K,
	parameter logic [3:0] MEM2_SIZE = cidtr_pkg::CIDTR_MSZ_NONE,
	parameter logic [3:0] MEM1_SIZE = cidtr_pkg::CIDTR_MSZ_32K,
	parameter logic [2:0] PROC = 3'h0,
	parameter logic [4:0] VERSION = 5'h00,
	parameter logic [31:0] EXT_VALUE = 32'h0000_0000
) (
	// Words
	output logic [31:0] cid_word,
	output logic [31:0] xtn_word
);
	// A reserved code would make software misread the part, so refuse it at build time.
	if (!cidtr_pkg::cidtr_type_ok(MEM_TYPE)) begin : g_bad_type
		$error("memory type code is reserved");
	end
	if (!cidtr_pkg::cidtr_ssz_ok(SRAM_SIZE)) begin : g_bad_sram
		$error("SRAM size code is reserved");
	end
	if (!cidtr_pkg::cidtr_msz_ok(MEM1_SIZE) || !cidtr_pkg::cidtr_msz_ok(MEM2_SIZE)) begin : g_bad_msz
		$error("program memory size code is reserved");
	end

	always_comb begin
		cid_word = 32'h0000_0000;
		cid_word[cidtr_pkg::CIDTR_EXT_POS] = EXTENSION_FLAG;
		cid_word[cidtr_pkg::CIDTR_TYPE_LSB +: 3] = MEM_TYPE;
		cid_word[cidtr_pkg::CIDTR_ARCHITECTURE_CODE_LSB +: 8] = ARCHITECTURE_CODE;
		cid_word[cidtr_pkg::CIDTR_SRAM_LSB +: 4] = SRAM_SIZE;
		// With ROM plus flash, the first field carries ROM and the second flash.
		cid_word[cidtr_pkg::CIDTR_MEM2_LSB +: 4] = MEM2_SIZE;
		cid_word[cidtr_pkg::CIDTR_MEM1_LSB +: 4] = MEM1_SIZE;
		cid_word[cidtr_pkg::CIDTR_PROC_LSB +: 3] = PROC;
		cid_word[cidtr_pkg::CIDTR_VER_LSB +: 5] = VERSION;
	end

	assign xtn_word = EXTENSION_FLAG ? EXT_VALUE : 32'h0000_0000;
endmodule : cidtr_id_word

// *** rtl/cidtr_top.sv ***
// Wishbone register bank with chip identification and the TAP reset override.
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module cidtr_top #(
	parameter logic EXTENSION_FLAG = 1'b0,
	parameter logic [2:0] MEM_TYPE = cidtr_pkg::CIDTR_TYPE_EFLASH,
	// Architecture value is arbitrary.
	parameter logic [7:0] ARCHITECTURE_CODE = 8'hA5,
	parameter logic [3:0] SRAM_SIZE = cidtr_pkg::CIDTR_SSZ_8K,
	parameter logic [3:0] MEM2_SIZE = cidtr_pkg::CIDTR_MSZ_NONE,
	parameter logic [3:0] MEM1_SIZE = cidtr_pkg::CIDTR_MSZ_32K,
	// Processor and version values are arbitrary.
	parameter logic [2:0] PROC = 3'h0,
	parameter logic [4:0] VERSION = 5'h00,
	parameter logic [31:0] EXT_VALUE = 32'h0000_0000
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic [cidtr_pkg::CIDTR_ADDR_W-1:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	output logic ERR_O,
	// Debug reset path
	input wire logic ICE_RESET_N,
	output logic TAP_RESET_N
);

	////////////////////////////////////////////////////////////////////////////////
	// Identification words.
	logic [31:0] cid_word;
	logic [31:0] xtn_word;

	cidtr_id_word #(
		.EXTENSION_FLAG(EXTENSION_FLAG),
		.MEM_TYPE(MEM_TYPE),
		.ARCHITECTURE_CODE(ARCHITECTURE_CODE),
		.SRAM_SIZE(SRAM_SIZE),
		.MEM2_SIZE(MEM2_SIZE),
		.MEM1_SIZE(MEM1_SIZE),
		.PROC(PROC),
		.VERSION(VERSION),
		.EXT_VALUE(EXT_VALUE)
	) u_id (
		.cid_word(cid_word),
		.xtn_word(xtn_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.
	logic ack_q;
	logic err_q;
	logic [31:0] dat_q;
	logic force_q;
	logic req;
	logic hit_cid;
	logic hit_xtn;
	logic hit_ovr;
	logic mapped;
	logic wr_ovr;

	// A request is taken once; the cycle that answers it blocks a second take.
	assign req = CYC_I & STB_I & ~ack_q & ~err_q;
	assign hit_cid = (ADR_I == cidtr_pkg::CIDTR_OFF_CID);
	assign hit_xtn = (ADR_I == cidtr_pkg::CIDTR_OFF_XTN);
	assign hit_ovr = (ADR_I == cidtr_pkg::CIDTR_OFF_OVR);
	assign mapped = hit_cid | hit_xtn | hit_ovr;
	assign wr_ovr = req & WE_I & hit_ovr & SEL_I[0];

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= req & mapped;
			err_q <= req & ~mapped;
		end
	end

	// Read data is registered; writes to the identification words fall through harmlessly.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			dat_q <= cidtr_pkg::CIDTR_DATA_RST;
		end else if (req & ~WE_I & mapped) begin
			if (hit_cid) begin
				dat_q <= cid_word;
			end else if (hit_xtn) begin
				dat_q <= xtn_word;
			end else begin
				dat_q <= {31'h0000_0000, force_q};
			end
		end else begin
			dat_q <= cidtr_pkg::CIDTR_DATA_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Override register.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			force_q <= cidtr_pkg::CIDTR_FORCE_RST;
		end else if (wr_ovr) begin
			force_q <= DAT_I[cidtr_pkg::CIDTR_FORCE_POS];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// TAP reset path.
	logic ice_sync;
	logic tap_q;

	cidtr_sync #(
		.RST_VAL(1'b0)
	) u_ice_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d(ICE_RESET_N),
		.q(ice_sync)
	);

	// Held asserted through system reset so the debug logic never starts half-reset.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tap_q <= cidtr_pkg::CIDTR_TAP_RST;
		end else if (force_q) begin
			tap_q <= 1'b0;
		end else begin
			tap_q <= ice_sync;
		end
	end

	assign DAT_O = dat_q;
	assign ACK_O = ack_q;
	assign ERR_O = err_q;
	assign TAP_RESET_N = tap_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_read(logic [7:0] off);
		CYC_I && STB_I && !WE_I && !ACK_O && !ERR_O && ADR_I == off;
	endsequence

	sequence s_write(logic [7:0] off);
		CYC_I && STB_I && WE_I && !ACK_O && !ERR_O && ADR_I == off;
	endsequence

	sequence s_one_ack;
		ACK_O ##1 !ACK_O;
	endsequence

	bus_ack_once_a: assert property (
		(CYC_I && STB_I && !ACK_O && !ERR_O && mapped) |=> s_one_ack)
		else $error("mapped request not answered by a single ack");

	cid_layout_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> ACK_O && DAT_O[31] == EXTENSION_FLAG && DAT_O[30:28] == MEM_TYPE
			&& DAT_O[27:20] == ARCHITECTURE_CODE && DAT_O[7:5] == PROC && DAT_O[4:0] == VERSION)
		else $error("identification word layout wrong");

	mem2_code_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> DAT_O[15:12] == MEM2_SIZE && cidtr_pkg::cidtr_msz_ok(DAT_O[15:12]))
		else $error("second memory size code wrong");

	sram_code_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> DAT_O[19:16] == SRAM_SIZE && cidtr_pkg::cidtr_ssz_ok(DAT_O[19:16]))
		else $error("SRAM size code wrong");

	mem_type_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> cidtr_pkg::cidtr_type_ok(DAT_O[30:28]))
		else $error("memory type code reserved");

	rom_flash_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) ##1 (DAT_O[30:28] == cidtr_pkg::CIDTR_TYPE_ROM_EFLASH)
			|-> DAT_O[11:8] == MEM1_SIZE && DAT_O[15:12] == MEM2_SIZE)
		else $error("ROM and flash sizes swapped");

	ext_flag_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> DAT_O[31] == EXTENSION_FLAG)
		else $error("extension flag wrong");

	xtn_zero_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_XTN) |=> ACK_O && (EXTENSION_FLAG || DAT_O == 32'h0000_0000)
			&& (!EXTENSION_FLAG || DAT_O == EXT_VALUE))
		else $error("extension word wrong for the flag");

	tap_pass_a: assert property (
		!force_q |=> TAP_RESET_N == $past(ice_sync))
		else $error("TAP reset does not follow emulator reset");

	tap_force_a: assert property (
		(s_write(cidtr_pkg::CIDTR_OFF_OVR) && SEL_I[0] && DAT_I[0]) |=> force_q ##1 !TAP_RESET_N)
		else $error("force write did not hold TAP reset low");

	tap_hold_a: assert property (
		force_q [*2] |-> !TAP_RESET_N)
		else $error("TAP reset released while forced");

	ovr_read_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_OVR) |=> DAT_O[31:1] == 31'h0000_0000 && DAT_O[0] == $past(force_q))
		else $error("override readback wrong");

	id_write_ign_a: assert property (
		(s_write(cidtr_pkg::CIDTR_OFF_CID) or s_write(cidtr_pkg::CIDTR_OFF_XTN)) |=> $stable(force_q) && DAT_O == 32'h0)
		else $error("write to identification had an effect");

	unmapped_err_a: assert property (
		(CYC_I && STB_I && !ACK_O && !ERR_O && !mapped) |=> ERR_O && !ACK_O ##1 !ERR_O)
		else $error("unmapped access not refused");

	////////////////////////////////////////////////////////////////////////////////
	// Answer shape and read data hygiene.
	ack_err_excl_a: assert property (
		!(ACK_O && ERR_O))
		else $error("ack and error raised together");

	ack_cause_a: assert property (
		ACK_O |-> $past(CYC_I) && $past(STB_I) && $past(mapped))
		else $error("ack without a mapped request");

	err_cause_a: assert property (
		ERR_O |-> $past(CYC_I) && $past(STB_I) && !$past(mapped))
		else $error("error without an unmapped request");

	answer_gap_a: assert property (
		(ACK_O || ERR_O) |=> !ACK_O && !ERR_O)
		else $error("answer stood longer than one cycle");

	dat_idle_a: assert property (
		!ACK_O |-> DAT_O == 32'h0000_0000)
		else $error("read data shown outside an ack");

	write_dat_a: assert property (
		s_write(cidtr_pkg::CIDTR_OFF_OVR) |=> ACK_O && !ERR_O && DAT_O == 32'h0000_0000)
		else $error("override write not acked cleanly");

	id_write_ack_a: assert property (
		s_write(cidtr_pkg::CIDTR_OFF_CID) |=> ACK_O && !ERR_O)
		else $error("identification write not acked");

	xtn_write_ack_a: assert property (
		s_write(cidtr_pkg::CIDTR_OFF_XTN) |=> ACK_O && !ERR_O && DAT_O == 32'h0000_0000)
		else $error("extension write not acked");

	mem1_code_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_CID) |=> DAT_O[11:8] == MEM1_SIZE && cidtr_pkg::cidtr_msz_ok(DAT_O[11:8]))
		else $error("first memory size code wrong");

	ovr_read_ack_a: assert property (
		s_read(cidtr_pkg::CIDTR_OFF_OVR) |=> ACK_O && !ERR_O)
		else $error("override read not acked");

	////////////////////////////////////////////////////////////////////////////////
	// Override register state.
	ovr_clear_a: assert property (
		(s_write(cidtr_pkg::CIDTR_OFF_OVR) && SEL_I[0] && !DAT_I[0]) |=> !force_q)
		else $error("clearing write left the force bit set");

	ovr_lane_a: assert property (
		(s_write(cidtr_pkg::CIDTR_OFF_OVR) && !SEL_I[0]) |=> $stable(force_q))
		else $error("override changed without its byte lane");

	force_keep_a: assert property (
		!wr_ovr |=> $stable(force_q))
		else $error("force bit changed without a write");

	id_read_pure_a: assert property (
		(s_read(cidtr_pkg::CIDTR_OFF_CID) or s_read(cidtr_pkg::CIDTR_OFF_XTN)) |=> $stable(force_q))
		else $error("identification read changed state");

	unmapped_pure_a: assert property (
		(CYC_I && STB_I && !ACK_O && !ERR_O && !mapped) |=> $stable(force_q) && DAT_O == 32'h0000_0000)
		else $error("unmapped access changed state");

	////////////////////////////////////////////////////////////////////////////////
	// Debug reset path.
	ice_sync_lat_a: assert property (
		($past(RST_N) && $past(RST_N, 2)) |-> ice_sync == $past(ICE_RESET_N, 2))
		else $error("emulator reset not synchronised in two stages");

	tap_release_a: assert property (
		(!force_q && ice_sync) |=> TAP_RESET_N)
		else $error("TAP reset not released with the emulator reset");

	tap_assert_a: assert property (
		(!force_q && !ice_sync) |=> !TAP_RESET_N)
		else $error("TAP reset not asserted with the emulator reset");

	// A saturating count of forced cycles checks a long hold without a long repetition.
	logic [3:0] forced_cnt_q;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			forced_cnt_q <= 4'h0;
		end else if (!force_q) begin
			forced_cnt_q <= 4'h0;
		end else if (forced_cnt_q != 4'hF) begin
			forced_cnt_q <= forced_cnt_q + 4'h1;
		end
	end

	tap_long_hold_a: assert property (
		(forced_cnt_q != 4'h0) |-> !TAP_RESET_N)
		else $error("TAP reset released during a long force");

endmodule : cidtr_top

// *** bench/cidtr_tap_model.sv ***
// Behavioural model of the emulator reset source and of the TAP reset input that it feeds.
`timescale 1ns/1ps
module cidtr_tap_model (
	// Clock
	input wire logic clk,
	// Emulator request from the bench and the TAP reset seen by the debug logic
	input wire logic drive_low,
	input wire logic tap_reset_n,
	output logic ice_reset_n,
	output logic tap_in_reset
);
	// The emulator changes its reset line just after an edge, never between edges.
	initial ice_reset_n = 1'b1;
	always @(posedge clk) begin
		ice_reset_n <= ~drive_low;
	end

	// The TAP controller sits in reset while its input is low.
	assign tap_in_reset = ~tap_reset_n;
endmodule : cidtr_tap_model

// *** bench/tb_top.sv ***
// Self-checking testbench for the chip identification and TAP reset control block.
`timescale 1ns/1ps
module tb_top;
	localparam logic [2:0] P_TYPE = cidtr_pkg::CIDTR_TYPE_ROM_EFLASH;
	// Architecture, processor and version values are arbitrary.
	localparam logic [7:0] P_ARCHITECTURE_CODE = 8'h5A;
	localparam logic [2:0] P_PROC = 3'h6;
	localparam logic [4:0] P_VER = 5'h0B;
	localparam logic [3:0] P_SRAM = cidtr_pkg::CIDTR_SSZ_160K;
	localparam logic [3:0] P_MEM2 = cidtr_pkg::CIDTR_MSZ_2048K;
	localparam logic [3:0] P_MEM1 = cidtr_pkg::CIDTR_MSZ_32K;
	// A non-zero extension value shows whether it leaks while the flag is clear.
	localparam logic [31:0] P_EXTV = 32'hC3C3_5A5A;
	localparam logic [31:0] ID_EXP = {1'b0, P_TYPE, P_ARCHITECTURE_CODE, P_SRAM, P_MEM2, P_MEM1, P_PROC, P_VER};

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ice_low = 1'b0;
	logic [31:0] dat_o;
	logic ack;
	logic err;
	logic tap_n;
	logic ice_n;
	logic tap_held;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	// Each note: bit 33 read data is checked, bit 32 error expected, then the data.
	logic [33:0] exp_q[$];

	always #2.5 clk = ~clk;

	cidtr_top #(.EXTENSION_FLAG(1'b0), .MEM_TYPE(P_TYPE), .ARCHITECTURE_CODE(P_ARCHITECTURE_CODE), .SRAM_SIZE(P_SRAM), .MEM2_SIZE(P_MEM2),
		.MEM1_SIZE(P_MEM1), .PROC(P_PROC), .VERSION(P_VER), .EXT_VALUE(P_EXTV)) cidtr_top_inst (
		.CLK(clk), .RST_N(rst_n), .ADR_I(adr), .DAT_I(dat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc),
		.STB_I(stb), .DAT_O(dat_o), .ACK_O(ack), .ERR_O(err), .ICE_RESET_N(ice_n), .TAP_RESET_N(tap_n));

	cidtr_tap_model cidtr_tap_model_inst (.clk(clk), .drive_low(ice_low), .tap_reset_n(tap_n),
		.ice_reset_n(ice_n), .tap_in_reset(tap_held));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, e, s);
		end
	endtask : chk_word

	task automatic chk_bit(input string name, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", name, e, s);
		end
	endtask : chk_bit

	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// One classic cycle; the request stands until the answer is sampled.
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
		input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		adr <= a;
		we <= w;
		dat <= d;
		sel <= s;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	////////////////////////////////////////////////////////////////////////////////
	// Scoreboard side: every answer takes the oldest note.
	always @(posedge clk) begin
		logic [33:0] e;
		if (ack === 1'b1 || err === 1'b1) begin
			chk_bit("note_pending", 1'b1, exp_q.size() != 0);
			e = exp_q.pop_front();
			chk_bit("err", e[32], err);
			if (e[33]) begin
				chk_word("rdata", e[31:0], dat_o);
			end
		end
	end

	// The longest path runs well under this ceiling.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [3:0] s;
		logic [7:0] a;
		logic f;
		f = 1'b0;
		d = $urandom(43);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wb(8'h08, 1'b0, 32'h0, 4'h0, {2'b10, 32'h0});
		wb(8'h00, 1'b0, 32'h0, 4'h0, {2'b10, ID_EXP});
		wb(8'h00, 1'b0, 32'h0, 4'h0, {2'b10, ID_EXP});
		wb(8'h04, 1'b0, 32'h0, 4'h0, {2'b10, 32'h0});
		wb(8'h00, 1'b1, ~ID_EXP, 4'hF, {2'b00, 32'h0});
		wb(8'h04, 1'b1, 32'hFFFF_FFFF, 4'hF, {2'b00, 32'h0});
		wb(8'h00, 1'b0, 32'h0, 4'h0, {2'b10, ID_EXP});
		wb(8'h04, 1'b0, 32'h0, 4'h0, {2'b10, 32'h0});
		for (int i = 0; i < 16; i++) begin
			d = $urandom;
			s = 4'($urandom);
			a = 8'($urandom);
			if (a == 8'h00 || a == 8'h04 || a == 8'h08) begin
				a = 8'h0C;
			end
			wb(a, d[1], d, s, {2'b11, 32'h0});
			wb(8'h08, 1'b1, d, s, {2'b00, 32'h0});
			if (s[0]) begin
				f = d[0];
			end
			wb(8'h08, 1'b0, 32'h0, 4'h0, {2'b10, 31'h0, f});
			ice_low <= d[2];
			repeat (5) @(posedge clk);
			chk_bit("tap_held", f | d[2], tap_held);
		end
		finish_test();
	end
endmodule : tb_top
